// *** hdl/adc_pair_pkg.sv ***
// Constants, field positions and types of the paired-channel converter control block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses below 256.
package adc_pair_pkg;
    localparam int NUM_PAIRS = 3;
    localparam int NUM_INPUTS = 2 * NUM_PAIRS;

    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_SRC   = 8'h04;
    localparam logic [7:0] OFF_STAT  = 8'h08;
    localparam logic [7:0] OFF_MASK  = 8'h0C;
    localparam logic [7:0] OFF_STATE = 8'h10;
    localparam logic [7:0] OFF_RES0  = 8'h20;
    localparam logic [7:0] OFF_RESN  = 8'h34;

    localparam int BIT_ON      = 15;
    localparam int BIT_HALT    = 13;
    localparam int BIT_GSW     = 10;
    localparam int BIT_JUSTIFY = 8;
    localparam int BIT_EARLY   = 7;
    localparam int BIT_ORDER   = 6;
    localparam int BIT_STAGGER = 5;
    localparam int DIV_LSB     = 0;
    localparam int DIV_W       = 3;

    localparam logic [15:0] CTRL_WMASK = 16'hA5E7;
    localparam logic [15:0] CTRL_RESET = 16'h0003;
    localparam logic [31:0] SRC_WMASK  = 32'h001F1F1F;
    localparam logic [31:0] SRC_RESET  = 32'h00000000;

    localparam int SRC_W      = 5;
    localparam int SRC_STRIDE = 8;
    localparam logic [4:0] SRC_NONE = 5'h00;
    localparam logic [4:0] SRC_GSW  = 5'h01;
    localparam logic [4:0] SRC_EXT  = 5'h02;

    localparam int RES_W        = 10;
    localparam int SAMPLE_TICKS = 2;
    localparam int PAIR_TICKS   = 24;
    localparam int HALF_TICKS   = PAIR_TICKS / 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} conv_state_t;
endpackage

// *** hdl/adc_pair_ctrl.sv ***
// Control logic of a paired-channel 10-bit converter: control register, sample-and-hold
// timing, pair queue, conversion sequencing, result store and interrupt.
// Assumes all inputs are synchronous to aclk and the analog core presents conv_data
// for the channel on conv_chan by the end of each half of a pair conversion.
//
// How it works
// - Converter runs only while converter_on is set.
// - idle_halt stops converter during device idle.
// - global_soft_trigger starts pairs selecting it.
// - global_soft_trigger is never cleared by hardware.
// - result_justify_select picks left or right justify.
// - early_irq_select picks first or second completion.
// - Order settings change only while converter off.
// - pair_sequence_select converts odd input first.
// - Staggered mode samples shared S&H at odd start.
// - Otherwise shared samples with dedicated unless busy.
// - Unimplemented control bits read as zero.
// - PWM or timer request starts a sample.
// - Each sample lasts two converter clocks.
// - Acquired sample queues a pending conversion.
// - One pair conversion takes 24 converter clocks.
`timescale 1ns/10ps
module adc_pair_ctrl
    import adc_pair_pkg::*;
(
    input  wire logic        aclk,       // System clock, 250 MHz.
    input  wire logic        aresetn,    // Synchronous reset, active low.
    input  wire logic [7:0]  awaddr,     // Write address.
    input  wire logic        awvalid,    // Write address valid.
    output logic             awready,    // Write address ready.
    input  wire logic [31:0] wdata,      // Write data.
    input  wire logic [3:0]  wstrb,      // Write byte strobes.
    input  wire logic        wvalid,     // Write data valid.
    output logic             wready,     // Write data ready.
    output logic [1:0]       bresp,      // Write response.
    output logic             bvalid,     // Write response valid.
    input  wire logic        bready,     // Write response ready.
    input  wire logic [7:0]  araddr,     // Read address.
    input  wire logic        arvalid,    // Read address valid.
    output logic             arready,    // Read address ready.
    output logic [31:0]      rdata,      // Read data.
    output logic [1:0]       rresp,      // Read response.
    output logic             rvalid,     // Read data valid.
    input  wire logic        rready,     // Read data ready.
    input  wire logic [2:0]  pwm_trig,   // Per-pair PWM or timer request pulses.
    input  wire logic        idle_mode,  // Device is in idle mode.
    input  wire logic [9:0]  conv_data,  // Raw converter output.
    output logic [2:0]       ded_sample, // Dedicated S&H sampling, per pair.
    output logic [2:0]       shr_sample, // Shared S&H sampling, per pair.
    output logic [2:0]       conv_chan,  // Input being converted.
    output logic             conv_busy,  // A pair conversion is under way.
    output logic             irq         // Interrupt, active high level.
);
    logic [15:0]       ctrl_r;
    logic [31:0]       src_r;
    logic [2:0]        stat_r;
    logic [2:0]        mask_r;
    logic [7:0]        awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              aw_have_r;
    logic              w_have_r;
    logic              gsw_d_r;
    logic [DIV_W-1:0]  div_cnt_r;
    logic [2:0]        pend_r;
    logic [2:0]        late_r;
    logic [1:0]        cur_pair_r;
    logic [3:0]        half_cnt_r;
    logic [4:0]        conv_tick_r;
    logic [RES_W-1:0]  res_r [NUM_INPUTS];
    conv_state_t       state_r;

    logic              wr_fire;
    logic [31:0]       wr_bytes;
    logic [15:0]       ctrl_nxt;
    logic              run;
    logic              tick;
    logic              gsw_rise;
    logic              grant_go;
    logic [1:0]        grant;
    logic              half_end;
    logic              first_done;
    logic              second_done;
    logic              odd_go;
    logic [1:0]        odd_pair;
    logic [2:0]        trig;
    logic [2:0]        ev_set;
    logic [31:0]       rd_word;
    logic              rd_err;
    logic [2:0]        rd_idx;

    assign wr_fire = aw_have_r && w_have_r && !bvalid;
    assign wr_bytes = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign run = ctrl_r[BIT_ON] && !(ctrl_r[BIT_HALT] && idle_mode);
    assign tick = run && (div_cnt_r == ctrl_r[DIV_LSB +: DIV_W]);
    assign gsw_rise = ctrl_r[BIT_GSW] && !gsw_d_r;
    assign half_end = tick && (half_cnt_r == 4'(HALF_TICKS - 1));
    assign first_done = (state_r == ST_FIRST) && half_end;
    assign second_done = (state_r == ST_SECOND) && half_end;

    always_comb begin
        ctrl_nxt = (ctrl_r & ~wr_bytes[15:0]) | (wdata_r[15:0] & wr_bytes[15:0]);
        ctrl_nxt = ctrl_nxt & CTRL_WMASK;
        if (ctrl_r[BIT_ON]) begin
            ctrl_nxt[BIT_EARLY] = ctrl_r[BIT_EARLY];
            ctrl_nxt[BIT_ORDER] = ctrl_r[BIT_ORDER];
        end
    end

    always_comb begin
        grant = 2'd0;
        for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                grant = 2'(i);
            end
        end
        grant_go = run && (state_r == ST_IDLE) && (pend_r != 3'h0);
    end

    assign odd_go = (grant_go && ctrl_r[BIT_ORDER]) || (first_done && !ctrl_r[BIT_ORDER]);
    assign odd_pair = grant_go ? grant : cur_pair_r;
    assign ev_set = (ctrl_r[BIT_EARLY] ? first_done : second_done) ? (3'h1 << cur_pair_r) : 3'h0;

    // Write side of the bus: address and data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awaddr_r <= awaddr;
                aw_have_r <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
                w_have_r <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awaddr_r == OFF_CTRL || awaddr_r == OFF_SRC || awaddr_r == OFF_STAT
                          || awaddr_r == OFF_MASK) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RESET;
            src_r <= SRC_RESET;
            mask_r <= 3'h0;
        end else if (wr_fire) begin
            if (awaddr_r == OFF_CTRL) begin
                ctrl_r <= ctrl_nxt;
            end
            if (awaddr_r == OFF_SRC) begin
                src_r <= ((src_r & ~wr_bytes) | (wdata_r & wr_bytes)) & SRC_WMASK;
            end
            if (awaddr_r == OFF_MASK && wstrb_r[0]) begin
                mask_r <= wdata_r[2:0];
            end
        end
    end

    // Sticky pair-done flags; a completion in the clearing cycle survives.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wr_fire && awaddr_r == OFF_STAT && wstrb_r[0]) begin
                stat_r <= (stat_r & ~wdata_r[2:0]) | ev_set;
            end else begin
                stat_r <= stat_r | ev_set;
            end
            irq <= ((stat_r | ev_set) & mask_r) != 3'h0;
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        rd_idx = 3'((araddr - OFF_RES0) >> 2);
        unique case (araddr)
            OFF_CTRL:  rd_word = {16'h0000, ctrl_r & CTRL_WMASK};
            OFF_SRC:   rd_word = src_r;
            OFF_STAT:  rd_word = {29'h0, stat_r};
            OFF_MASK:  rd_word = {29'h0, mask_r};
            OFF_STATE: rd_word = {26'h0, pend_r, conv_busy, cur_pair_r};
            default: begin
                if (araddr >= OFF_RES0 && araddr <= OFF_RESN && araddr[1:0] == 2'b00) begin
                    if (ctrl_r[BIT_JUSTIFY]) begin
                        rd_word = {16'h0000, res_r[rd_idx], 6'h00};
                    end else begin
                        rd_word = {16'h0000, 6'h00, res_r[rd_idx]};
                    end
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Converter clock: one tick every divider+1 system clocks.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_r <= 3'h0;
            gsw_d_r <= 1'b0;
        end else begin
            gsw_d_r <= ctrl_r[BIT_GSW];
            if (!run || tick) begin
                div_cnt_r <= 3'h0;
            end else begin
                div_cnt_r <= div_cnt_r + 3'h1;
            end
        end
    end

    generate
        for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
            logic [4:0] src;
            logic       ded_end;
            logic       shr_go;
            logic       d_cnt_r;
            logic       s_cnt_r;
            assign src = src_r[p*SRC_STRIDE +: SRC_W];
            assign trig[p] = run && ((src == SRC_GSW && gsw_rise) || (src == SRC_EXT && pwm_trig[p]));
            assign ded_end = ded_sample[p] && tick && (d_cnt_r == 1'(SAMPLE_TICKS - 1));
            assign shr_go = (trig[p] && !ded_sample[p] && !ctrl_r[BIT_STAGGER] && !conv_busy)
                || (late_r[p] && grant_go && grant == 2'(p))
                || (odd_go && odd_pair == 2'(p) && ctrl_r[BIT_STAGGER]);

            always_ff @(posedge aclk) begin
                if (!aresetn || !run) begin
                    ded_sample[p] <= 1'b0;
                    d_cnt_r <= 1'b0;
                end else if (trig[p] && !ded_sample[p]) begin
                    ded_sample[p] <= 1'b1;
                    d_cnt_r <= 1'b0;
                end else if (ded_sample[p] && tick) begin
                    ded_sample[p] <= !ded_end;
                    d_cnt_r <= d_cnt_r + 1'b1;
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn || !run) begin
                    shr_sample[p] <= 1'b0;
                    s_cnt_r <= 1'b0;
                end else if (shr_go) begin
                    shr_sample[p] <= 1'b1;
                    s_cnt_r <= 1'b0;
                end else if (shr_sample[p] && tick) begin
                    shr_sample[p] <= s_cnt_r != 1'(SAMPLE_TICKS - 1);
                    s_cnt_r <= s_cnt_r + 1'b1;
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn || !run) begin
                    pend_r[p] <= 1'b0;
                    late_r[p] <= 1'b0;
                end else begin
                    if (ded_end) begin
                        pend_r[p] <= 1'b1;
                    end else if (grant_go && grant == 2'(p)) begin
                        pend_r[p] <= 1'b0;
                    end
                    if (trig[p] && !ded_sample[p] && !ctrl_r[BIT_STAGGER] && conv_busy) begin
                        late_r[p] <= 1'b1;
                    end else if (grant_go && grant == 2'(p)) begin
                        late_r[p] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            state_r <= ST_IDLE;
            conv_busy <= 1'b0;
            conv_chan <= 3'h0;
            cur_pair_r <= 2'd0;
            half_cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (grant_go) begin
                        state_r <= ST_FIRST;
                        conv_busy <= 1'b1;
                        cur_pair_r <= grant;
                        conv_chan <= {grant, ctrl_r[BIT_ORDER]};
                        half_cnt_r <= 4'h0;
                    end
                end
                ST_FIRST, ST_SECOND: begin
                    if (half_end) begin
                        half_cnt_r <= 4'h0;
                        conv_chan[0] <= !conv_chan[0];
                        state_r <= (state_r == ST_FIRST) ? ST_SECOND : ST_IDLE;
                        conv_busy <= state_r == ST_FIRST;
                    end else if (tick) begin
                        half_cnt_r <= half_cnt_r + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                res_r[i] <= 10'h000;
            end
        end else if (first_done || second_done) begin
            res_r[conv_chan] <= conv_data;
        end
    end

    // Ticks spent on the current pair, read only by the a_pair_len check below.
    always_ff @(posedge aclk) begin
        if (!aresetn || grant_go) begin
            conv_tick_r <= 5'h00;
        end else if (conv_busy && tick) begin
            conv_tick_r <= conv_tick_r + 5'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_off_stops;
        !ctrl_r[BIT_ON] |=> state_r == ST_IDLE && !conv_busy && pend_r == 3'h0;
    endproperty
    a_off_stops: assert property (p_off_stops) else $error("converter active while off");

    property p_idle_halt;
        ctrl_r[BIT_HALT] && idle_mode |=> !conv_busy && ded_sample == 3'h0;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("converter ran in idle");

    property p_gsw_start;
        gsw_rise && run && src_r[SRC_W-1:0] == SRC_GSW && !ded_sample[0] |=> ded_sample[0];
    endproperty
    a_gsw_start: assert property (p_gsw_start) else $error("global trigger ignored");

    property p_gsw_sticky;
        $fell(ctrl_r[BIT_GSW]) |-> $past(wr_fire) && $past(awaddr_r) == OFF_CTRL;
    endproperty
    a_gsw_sticky: assert property (p_gsw_sticky) else $error("trigger bit self-cleared");

    property p_justify;
        $rose(rvalid) && $past(araddr) == OFF_RES0 && ctrl_r[BIT_JUSTIFY]
            |-> rdata[5:0] == 6'h00 && rdata[31:16] == 16'h0000;
    endproperty
    a_justify: assert property (p_justify) else $error("left result not justified");

    property p_early;
        first_done && ctrl_r[BIT_EARLY] |=> stat_r[$past(cur_pair_r)];
    endproperty
    a_early: assert property (p_early) else $error("early event missing");

    property p_lock;
        ctrl_r[BIT_ON] && $past(ctrl_r[BIT_ON]) |-> $stable(ctrl_r[BIT_ORDER]);
    endproperty
    a_lock: assert property (p_lock) else $error("order changed while on");

    property p_order;
        grant_go |=> conv_chan[0] == $past(ctrl_r[BIT_ORDER]) && conv_busy;
    endproperty
    a_order: assert property (p_order) else $error("wrong first input");

    property p_ro_zero;
        $rose(rvalid) && $past(araddr) == OFF_CTRL |-> (rdata & ~{16'h0000, CTRL_WMASK}) == 32'h0;
    endproperty
    a_ro_zero: assert property (p_ro_zero) else $error("reserved bit read nonzero");

    // Ticks spent by the pair 0 dedicated sample, read only by the check below.
    logic [1:0] ded0_ticks_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !ded_sample[0]) begin
            ded0_ticks_r <= 2'h0;
        end else if (tick) begin
            ded0_ticks_r <= ded0_ticks_r + 2'h1;
        end
    end

    property p_sample_len;
        $fell(ded_sample[0]) && $past(run) |-> ded0_ticks_r == 2'(SAMPLE_TICKS);
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample window not two ticks");

    property p_pair_len;
        second_done |-> conv_tick_r == 5'(PAIR_TICKS - 1);
    endproperty
    a_pair_len: assert property (p_pair_len) else $error("pair not 24 ticks");

    property p_queue;
        ded_sample[1] && g_pair[1].ded_end |=> pend_r[1] || conv_busy;
    endproperty
    a_queue: assert property (p_queue) else $error("acquired sample dropped");

    c_early_irq: cover property (first_done && ctrl_r[BIT_EARLY] && mask_r != 3'h0);
    c_stagger: cover property (odd_go && ctrl_r[BIT_STAGGER]);
    c_two_pending: cover property (conv_busy && pend_r[0] && pend_r[2]);
endmodule

// *** test/analog_src.sv ***
// Analog front end model: presents a code for the input under conversion.
// Assumes conv_chan is steady for each half of a pair conversion.
`timescale 1ns/10ps
module analog_src (
    input  wire logic       aclk,      // System clock.
    input  wire logic [9:0] salt,      // Per-run data offset.
    input  wire logic       conv_busy, // Conversion under way.
    input  wire logic [2:0] conv_chan, // Selected input.
    output logic      [9:0] conv_data  // Code of the selected input.
);
    initial conv_data = 10'h155;
    // pairs converted; outside a conversion the code toggles so stale data never matches.
    always @(posedge aclk) begin
        conv_data <= conv_busy ? ({conv_chan, 7'h00} ^ salt) : ~conv_data;
    end
endmodule

// *** test/testbench.sv ***
// Self-checking bench of the paired converter control block.
// Assumes the analog model answers every conversion with a per-input code.
`timescale 1ns/10ps
module testbench;
    import adc_pair_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, wr_resp;
    logic awready, wready, bvalid, arready, rvalid, conv_busy, irq, idle_mode = 0;
    logic [2:0] pwm_trig = 3'h0, ded_sample, shr_sample, conv_chan;
    logic [9:0] conv_data, salt = 10'h0;
    int seed = 32'h87EC;
    int miscompares = 0, total_checks = 0, cycles = 0;

    always #2 aclk = ~aclk;
    adc_pair_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pwm_trig(pwm_trig), .idle_mode(idle_mode), .conv_data(conv_data),
        .ded_sample(ded_sample), .shr_sample(shr_sample), .conv_chan(conv_chan),
        .conv_busy(conv_busy), .irq(irq));
    analog_src model (.aclk(aclk), .salt(salt), .conv_busy(conv_busy), .conv_chan(conv_chan),
        .conv_data(conv_data));

    task automatic print_verdict;
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(n, e, d);
    endtask

    task automatic pulse(input int p);
        @(posedge aclk);
        pwm_trig <= 3'h1 << p;
        @(posedge aclk);
        pwm_trig <= 3'h0;
    endtask

    function automatic logic [31:0] code(input bit j, input int ch);
        logic [9:0] v;
        v = {ch[2:0], 7'h00} ^ salt;
        return j ? {16'h0, v, 6'h00} : {22'h0, v};
    endfunction

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] ctl;
        int p, n;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk("ctrl_reset", OFF_CTRL, {16'h0, CTRL_RESET});
        axw(OFF_CTRL, 32'h7FFF);
        rdchk("ctrl_unimpl", OFF_CTRL, 32'h25E7);
        axr(8'hF0, d, r);
        chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axw(8'hF0, 32'h0);
        chk("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
        axw(OFF_MASK, 32'h7);
        for (int i = 0; i < 8; i++) begin
            p = i % 3;
            ctl = {7'h0, i[0], i[1], i[2], 6'h0} | 16'($random(seed) & 32'h20);
            if (i % 3 == 2) ctl[5] = 1'b1;
            salt <= 10'($random(seed));
            axw(OFF_STAT, 32'h7);
            axw(OFF_SRC, 32'h2 << (8 * p));
            axw(OFF_CTRL, {16'h0, ctl});
            axw(OFF_CTRL, {16'h0, ctl | 16'h8000});
            pulse(p);
            @(posedge aclk);
            chk("ded_sample", 32'h1 << p, {29'h0, ded_sample});
            chk("shr_sample", ctl[5] ? 32'h0 : 32'h1 << p, {29'h0, shr_sample});
            n = 0;
            while (!conv_busy && n < 40) begin
                @(posedge aclk);
                n++;
            end
            chk("first_chan", 2 * p + i[2], {29'h0, conv_chan});
            chk("shr_first", ctl[5] && i[2] ? 32'h1 << p : 32'h0, {29'h0, shr_sample});
            n = 0;
            while (!irq && n < 100) begin
                @(posedge aclk);
                n++;
            end
            chk("irq_delay", i[1] ? HALF_TICKS : PAIR_TICKS, n);
            n = 0;
            while (conv_busy && n < 40) begin
                @(posedge aclk);
                n++;
            end
            rdchk("status", OFF_STAT, 32'h1 << p);
            rdchk("even_res", OFF_RES0 + 8 * p, code(i[0], 2 * p));
            rdchk("odd_res", OFF_RES0 + 8 * p + 4, code(i[0], 2 * p + 1));
        end
        axw(OFF_STAT, 32'h7);
        axw(OFF_SRC, 32'h010101);
        axw(OFF_CTRL, 32'h0000);
        axw(OFF_CTRL, 32'h8400);
        n = 0;
        do begin
            axr(OFF_STAT, d, r);
            n++;
        end while (d != 32'h7 && n < 40);
        chk("all_pairs", 32'h7, d);
        rdchk("gsw_kept", OFF_CTRL, 32'h8400);
        axw(OFF_CTRL, 32'h84C0);
        rdchk("order_lock", OFF_CTRL, 32'h8400);
        chk("irq_on", 32'h1, {31'h0, irq});
        axw(OFF_MASK, 32'h0);
        @(posedge aclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        axw(OFF_STAT, 32'h7);
        rdchk("status_clr", OFF_STAT, 32'h0);
        axw(OFF_SRC, 32'h2);
        axw(OFF_CTRL, 32'h0000);
        pulse(0);
        repeat (40) @(posedge aclk);
        rdchk("off_status", OFF_STAT, 32'h0);
        idle_mode <= 1'b1;
        axw(OFF_CTRL, 32'hA000);
        pulse(0);
        repeat (40) @(posedge aclk);
        rdchk("idle_status", OFF_STAT, 32'h0);
        axw(OFF_CTRL, 32'h8000);
        pulse(0);
        repeat (40) @(posedge aclk);
        rdchk("idle_run", OFF_STAT, 32'h1);
        print_verdict();
    end
endmodule
